//--- core/bzc_top.v
// Purpose: zone colour menu, lockout, dim and relay ordering of a bargraph meter
// Assumes: one 20 MHz clock; buttons, lock, dim, strap pins are asynchronous
// Notes:   lock and dim pins are active low (closed to common)
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "bzc_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - menu starts on below-zone colour; advance shows first-limit prompt, stored value.
// - advance after first-limit colour shows second-limit prompt with stored choice.
// - advance after second-limit colour shows third-limit prompt, same three colours.
// - advance after third-limit colour shows fourth-limit prompt with stored value.
// - advance on fourth-limit colour leaves menu, back to measurement display.
// - horizontal bars read below as left and above as right.
// - lockout closed: parameters viewable, every change refused.
// - dim closed: display runs at half the selected brightness.
// - setpoint outputs drive relay positions in order third, first, fourth, second.
// - whole bar shows one colour, that of the zone the reading is in.
// - equal limits with different colours show the highest-numbered limit colour.
// - colour menu only with tricolour bar; mono bar returns straight to display.
module bzc_top #(
   parameter DW = 14
) (
   input  wire                 clock,
   input  wire                 rst_n,
   input  wire [3:0]           addr,
   input  wire [15:0]          wdata,
   input  wire                 wr,
   input  wire                 rd,
   output reg  [15:0]          rdata_q,
   input  wire                 btn_adv,
   input  wire                 btn_up,
   input  wire                 btn_down,
   input  wire                 lock_pin_n,
   input  wire                 dim_pin_n,
   input  wire                 tricolor_pin,
   input  wire                 horiz_pin,
   input  wire                 relay_setup_done,
   input  wire signed [DW-1:0] reading,
   input  wire [3:0]           sp_active,
   input  wire                 nv_restore,
   input  wire [9:0]           nv_rdata,
   output reg                  nv_store_q,
   output reg  [9:0]           nv_wdata_q,
   output reg                  menu_active_q,
   output reg  [2:0]           prompt_q,
   output reg  [1:0]           prompt_color_q,
   output reg  [1:0]           bar_color_q,
   output reg                  bar_horiz_q,
   output reg  [3:0]           relay_q,
   output reg  [7:0]           duty_q
);

   // one-hot menu states
   localparam [5:0] ST_MEAS  = 6'h01;
   localparam [5:0] ST_BELOW = 6'h02;
   localparam [5:0] ST_LIM1  = 6'h04;
   localparam [5:0] ST_LIM2  = 6'h08;
   localparam [5:0] ST_LIM3  = 6'h10;
   localparam [5:0] ST_LIM4  = 6'h20;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   wire [2:0] btn_s;
   wire [1:0] cont_n_s;
   wire [1:0] strap_s;

   bzc_sync #(.W(3), .RST_V(1'b0)) u_sync_btn (
      .clock (clock),
      .rst_n (rst_n),
      .pin   ({btn_down, btn_up, btn_adv}),
      .level (btn_s)
   );

   // open contacts idle high, so the reset level is high
   bzc_sync #(.W(2), .RST_V(1'b1)) u_sync_cont (
      .clock (clock),
      .rst_n (rst_n),
      .pin   ({dim_pin_n, lock_pin_n}),
      .level (cont_n_s)
   );

   bzc_sync #(.W(2), .RST_V(1'b0)) u_sync_strap (
      .clock (clock),
      .rst_n (rst_n),
      .pin   ({horiz_pin, tricolor_pin}),
      .level (strap_s)
   );

   wire locked  = ~cont_n_s[0];
   wire dimmed  = ~cont_n_s[1];
   wire tri_bar = strap_s[0];

   ////////////////////////////////////////////////////////////////////////////
   // button edges; no debounce here, a bouncing contact gives extra steps

   reg  [2:0] btn_prev_q;
   wire [2:0] btn_rise = btn_s & ~btn_prev_q;
   wire       adv_p    = btn_rise[0];
   wire       up_p     = btn_rise[1] & ~btn_rise[0];
   wire       down_p   = btn_rise[2] & ~btn_rise[1] & ~btn_rise[0];

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         btn_prev_q <= 3'h0;
      end else begin
         btn_prev_q <= btn_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state and configuration registers

   reg [5:0]    state_q;
   reg [1:0]    edit_q;
   reg [9:0]    colors_q;
   reg [1:0]    bright_q;
   reg [4*DW-1:0] limits_q;
   reg          refused_q;

   wire in_menu = ~state_q[0];

   // index of the zone being edited, 0 for below
   reg [2:0] cur_idx;
   always @* begin
      case (state_q)
         ST_BELOW: cur_idx = 3'h0;
         ST_LIM1:  cur_idx = 3'h1;
         ST_LIM2:  cur_idx = 3'h2;
         ST_LIM3:  cur_idx = 3'h3;
         ST_LIM4:  cur_idx = 3'h4;
         default:  cur_idx = 3'h0;
      endcase
   end

   // colour codes above red are saturated so only three colours exist
   function [1:0] clamp;
      input [1:0] c;
      begin
         clamp = (c == 2'h3) ? `BZC_RED : c;
      end
   endfunction

   // stored colour of one zone
   function [1:0] pick;
      input [9:0] c;
      input [2:0] i;
      begin
         case (i)
            3'h0:    pick = c[1:0];
            3'h1:    pick = c[3:2];
            3'h2:    pick = c[5:4];
            3'h3:    pick = c[7:6];
            3'h4:    pick = c[9:8];
            default: pick = c[1:0];
         endcase
      end
   endfunction

   wire bus_wr_cfg = wr && (addr == `BZC_A_CTRL || addr == `BZC_A_COLORS ||
                            (addr >= `BZC_A_LIM1 && addr <= `BZC_A_LIM4));
   wire edit_try   = in_menu && (up_p || down_p);
   wire refuse_ev  = locked && (bus_wr_cfg || edit_try);
   wire commit     = in_menu && adv_p && !locked;
   wire [9:0] committed = colors_q & ~(10'h3 << {cur_idx, 1'b0}) |
                          ({8'h00, edit_q} << {cur_idx, 1'b0});

   ////////////////////////////////////////////////////////////////////////////
   // colour menu sequence

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_MEAS;
         edit_q  <= `BZC_GREEN;
      end else begin
         case (state_q)
            ST_MEAS: begin
               if (relay_setup_done && tri_bar) begin
                  state_q <= ST_BELOW;
                  edit_q  <= pick(colors_q, 3'h0);
               end
            end
            ST_BELOW, ST_LIM1, ST_LIM2, ST_LIM3, ST_LIM4: begin
               if (adv_p) begin
                  // next prompt shows its stored colour
                  edit_q <= pick(colors_q, cur_idx + 3'h1);
                  case (state_q)
                     ST_BELOW: state_q <= ST_LIM1;
                     ST_LIM1:  state_q <= ST_LIM2;
                     ST_LIM2:  state_q <= ST_LIM3;
                     ST_LIM3:  state_q <= ST_LIM4;
                     default:  state_q <= ST_MEAS;
                  endcase
               end else if (up_p && !locked) begin
                  edit_q <= (edit_q >= `BZC_RED) ? `BZC_GREEN : edit_q + 2'h1;
               end else if (down_p && !locked) begin
                  edit_q <= (edit_q == `BZC_GREEN) ? `BZC_RED : edit_q - 2'h1;
               end
            end
            default: begin
               state_q <= ST_MEAS;
            end
         endcase
      end
   end

   // colour store: restore beats operator commit beats bus write
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         colors_q   <= `BZC_COLORS_RST;
         nv_store_q <= 1'b0;
         nv_wdata_q <= `BZC_COLORS_RST;
      end else begin
         nv_store_q <= 1'b0;
         if (nv_restore) begin
            colors_q <= {clamp(nv_rdata[9:8]), clamp(nv_rdata[7:6]), clamp(nv_rdata[5:4]),
                         clamp(nv_rdata[3:2]), clamp(nv_rdata[1:0])};
         end else if (commit) begin
            colors_q   <= committed;
            nv_wdata_q <= committed;
            nv_store_q <= 1'b1;
         end else if (wr && addr == `BZC_A_COLORS && !locked) begin
            colors_q   <= {clamp(wdata[9:8]), clamp(wdata[7:6]), clamp(wdata[5:4]),
                           clamp(wdata[3:2]), clamp(wdata[1:0])};
            nv_wdata_q <= {clamp(wdata[9:8]), clamp(wdata[7:6]), clamp(wdata[5:4]),
                           clamp(wdata[3:2]), clamp(wdata[1:0])};
            nv_store_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // brightness, limits and refused flag from the register port

   integer k;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bright_q  <= `BZC_BRIGHT_RST;
         limits_q  <= {4{`BZC_LIM_RST}};
         refused_q <= 1'b0;
      end else begin
         if (wr && !locked && addr == `BZC_A_CTRL) begin
            bright_q <= wdata[1:0];
         end
         for (k = 0; k < 4; k = k + 1) begin
            if (wr && !locked && addr == `BZC_A_LIM1 + k[3:0]) begin
               limits_q[k*DW +: DW] <= wdata[DW-1:0];
            end
         end
         // a new refusal wins over a clear in the same cycle
         if (refuse_ev) begin
            refused_q <= 1'b1;
         end else if (wr && addr == `BZC_A_STATUS && wdata[`BZC_ST_REFUSED]) begin
            refused_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bar colour

   wire [1:0] zone_color;

   bzc_zone #(.DW(DW)) u_zone (
      .reading (reading),
      .limits  (limits_q),
      .colors  (colors_q),
      .color   (zone_color)
   );

   // display duty of the selected level, halved while dimmed
   reg [7:0] duty_d;
   always @* begin
      case (bright_q)
         2'h0:    duty_d = `BZC_DUTY_0;
         2'h1:    duty_d = `BZC_DUTY_1;
         2'h2:    duty_d = `BZC_DUTY_2;
         default: duty_d = `BZC_DUTY_3;
      endcase
      if (dimmed) begin
         duty_d = {1'b0, duty_d[7:1]};
      end
   end

   // display side outputs, all registered
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         menu_active_q  <= 1'b0;
         prompt_q       <= `BZC_P_NONE;
         prompt_color_q <= `BZC_GREEN;
         bar_color_q    <= `BZC_GREEN;
         bar_horiz_q    <= 1'b0;
         relay_q        <= 4'h0;
         duty_q         <= `BZC_DUTY_3;
      end else begin
         menu_active_q  <= in_menu;
         prompt_q       <= in_menu ? cur_idx + `BZC_P_BELOW : `BZC_P_NONE;
         prompt_color_q <= edit_q;
         bar_color_q    <= zone_color;
         // zones are positional, so left/right on a horizontal bar needs no other logic
         bar_horiz_q    <= strap_s[1];
         relay_q        <= {sp_active[1], sp_active[3], sp_active[0], sp_active[2]};
         duty_q         <= duty_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register read port, data in the cycle after the strobe

   reg [15:0] rd_d;
   always @* begin
      case (addr)
         `BZC_A_CTRL:   rd_d = {14'h0000, bright_q};
         `BZC_A_COLORS: rd_d = {6'h00, colors_q};
         `BZC_A_LIM1:   rd_d = {{(16-DW){limits_q[DW-1]}}, limits_q[DW-1:0]};
         `BZC_A_LIM2:   rd_d = {{(16-DW){limits_q[2*DW-1]}}, limits_q[2*DW-1:DW]};
         `BZC_A_LIM3:   rd_d = {{(16-DW){limits_q[3*DW-1]}}, limits_q[3*DW-1:2*DW]};
         `BZC_A_LIM4:   rd_d = {{(16-DW){limits_q[4*DW-1]}}, limits_q[4*DW-1:3*DW]};
         `BZC_A_STATUS: rd_d = {9'h000, bar_color_q, refused_q, in_menu, tri_bar, dimmed, locked};
         `BZC_A_RELAY:  rd_d = {12'h000, relay_q};
         default:       rd_d = 16'h0000;
      endcase
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= rd ? rd_d : 16'h0000;
      end
   end

endmodule

//--- core/bzc_consts.vh
// Purpose: shared constants of the bargraph zone colour block
// Assumes: included by bare name from the top and zone design files of the block
// Notes:   offsets are word addresses on the plain register port
`ifndef BZC_CONSTS_VH
`define BZC_CONSTS_VH

// register addresses
`define BZC_A_CTRL    4'h0
`define BZC_A_COLORS  4'h1
`define BZC_A_LIM1    4'h2
`define BZC_A_LIM2    4'h3
`define BZC_A_LIM3    4'h4
`define BZC_A_LIM4    4'h5
`define BZC_A_STATUS  4'h6
`define BZC_A_RELAY   4'h7

// status fields
`define BZC_ST_LOCK    0
`define BZC_ST_DIM     1
`define BZC_ST_TRI     2
`define BZC_ST_MENU    3
`define BZC_ST_REFUSED 4
`define BZC_ST_BAR_LO  5

// colour codes, two bits each
`define BZC_GREEN  2'h0
`define BZC_ORANGE 2'h1
`define BZC_RED    2'h2

// colour field reset: below, first..fourth limit from low bits up
`define BZC_COLORS_RST 10'h290

// prompt codes shown on the digits
`define BZC_P_NONE  3'h0
`define BZC_P_BELOW 3'h1
`define BZC_P_LIM1  3'h2
`define BZC_P_LIM2  3'h3
`define BZC_P_LIM3  3'h4
`define BZC_P_LIM4  3'h5

// brightness levels and display duty per level
`define BZC_BRIGHT_RST 2'h3
`define BZC_DUTY_0     8'h40
`define BZC_DUTY_1     8'h80
`define BZC_DUTY_2     8'hc0
`define BZC_DUTY_3     8'hff

// limit reset values, 14'h270f, which the signed compare reads as -6385
`define BZC_LIM_RST    14'h270f

`endif

//--- core/bzc_sync.v
// Purpose: two flip-flop synchroniser for asynchronous pin levels
// Assumes: inputs change slowly compared with the clock
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps

module bzc_sync #(
   parameter W     = 1,
   parameter RST_V = 1'b0
) (
   input  wire         clock,
   input  wire         rst_n,
   input  wire [W-1:0] pin,
   output wire [W-1:0] level
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // both stages reset to the idle level of the pins
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= {W{RST_V}};
         sync_q <= {W{RST_V}};
      end else begin
         meta_q <= pin;
         sync_q <= meta_q;
      end
   end

   assign level = sync_q;

endmodule

//--- core/bzc_zone.v
// Purpose: choose the single colour of the whole bar from the reading
// Assumes: reading and limits are signed counts of the same scale
// Notes:   purely combinational, registered by the caller
`timescale 1ns/1ps
`include "bzc_consts.vh"

module bzc_zone #(
   parameter DW = 14
) (
   input  wire signed [DW-1:0] reading,
   input  wire [4*DW-1:0]      limits,
   input  wire [9:0]           colors,
   output reg  [1:0]           color
);

   integer            i;
   reg                found;
   reg signed [DW-1:0] best;
   reg signed [DW-1:0] lim;

   // the highest limit below the reading names the zone; ">=" on the
   // running best lets a higher-numbered limit win a tie
   always @* begin
      found = 1'b0;
      best  = {DW{1'b0}};
      lim   = {DW{1'b0}};
      color = colors[1:0];
      for (i = 0; i < 4; i = i + 1) begin
         lim = limits[i*DW +: DW];
         if (reading > lim && (!found || lim >= best)) begin
            found = 1'b1;
            best  = lim;
            color = colors[(i+1)*2 +: 2];
         end
      end
   end

endmodule

//--- testbench/bzc_checker.sv
// Purpose: port assertions for the zone colour block
// Assumes: bound to every bzc_top instance
// Notes:   pin rules leave room for the two-stage sync
`timescale 1ns/1ps
`include "bzc_consts.vh"

module bzc_checker #(
   parameter DW = 14
) (
   input wire       clock,
   input wire       rst_n,
   input wire [3:0] sp_active,
   input wire [3:0] relay_q,
   input wire       menu_active_q,
   input wire [2:0] prompt_q,
   input wire       dim_pin_n,
   input wire [7:0] duty_q,
   input wire       horiz_pin,
   input wire       bar_horiz_q,
   input wire       lock_pin_n,
   input wire       nv_store_q,
   input wire [1:0] bar_color_q,
   input wire       tricolor_pin,
   input wire       relay_setup_done
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////
   // relay positions carry third, first, fourth, second
   // the edge that leaves reset still shows the reset value, so skip it
   chk_relay_order: assert property ($past(rst_n)
      |-> relay_q == $past({sp_active[1], sp_active[3], sp_active[0], sp_active[2]}))
      else $error("relay order wrong");
   // the menu always opens on the below-zone prompt
   chk_menu_start: assert property ($rose(menu_active_q) |-> prompt_q == `BZC_P_BELOW)
      else $error("menu opened on wrong prompt");
   // prompts only ever step one place forward
   chk_prompt_step: assert property ((menu_active_q && $past(menu_active_q) && $changed(prompt_q))
      |-> prompt_q == $past(prompt_q) + 3'h1)
      else $error("prompt skipped");
   chk_menu_exit: assert property ($fell(menu_active_q) |-> $past(prompt_q) == `BZC_P_LIM4)
      else $error("menu left early");
   // halved duties all sit below the top bit
   chk_dim_half: assert property ((!dim_pin_n) [*6] |-> duty_q < 8'h80)
      else $error("dim not halved");
   chk_bright_full: assert property (dim_pin_n [*6] |-> duty_q inside {8'h40, 8'h80, 8'hc0, 8'hff})
      else $error("duty off table");
   chk_horiz_copy: assert property ($stable(horiz_pin) [*5] |-> bar_horiz_q == horiz_pin)
      else $error("horizontal strap not followed");
   chk_lock_nostore: assert property ((!lock_pin_n) [*6] |-> !nv_store_q)
      else $error("store while locked");
   chk_bar_legal: assert property (bar_color_q != 2'h3)
      else $error("bar colour code illegal");
   chk_mono_nomenu: assert property ((!tricolor_pin) [*4] ##0 (relay_setup_done && !menu_active_q)
      |-> ##2 !menu_active_q)
      else $error("menu opened on mono bar");

   cover_menu_open: cover property ($rose(menu_active_q));
   cover_menu_exit: cover property ($fell(menu_active_q));
   cover_dim: cover property (!dim_pin_n && duty_q == 8'h7f);
endmodule

bind bzc_top bzc_checker #(.DW(DW)) i_bzc_checker (.clock(clock), .rst_n(rst_n), .sp_active(sp_active),
   .relay_q(relay_q), .menu_active_q(menu_active_q), .prompt_q(prompt_q), .dim_pin_n(dim_pin_n),
   .duty_q(duty_q), .horiz_pin(horiz_pin), .bar_horiz_q(bar_horiz_q), .lock_pin_n(lock_pin_n),
   .nv_store_q(nv_store_q), .bar_color_q(bar_color_q), .tricolor_pin(tricolor_pin),
   .relay_setup_done(relay_setup_done));

//--- testbench/bzc_operator.sv
// Purpose: operator at the front buttons and rear contacts
// Assumes: buttons high while pressed, contacts pulled up when open
// Notes:   no bounce modelled, the design has no debounce
`timescale 1ns/1ps

module bzc_operator (
   input  wire clock,
   output reg  btn_adv,
   output reg  btn_up,
   output reg  btn_down,
   output reg  lock_pin_n,
   output reg  dim_pin_n
);
   // contacts open at power-up, pull-up holds them high
   initial begin
      btn_adv = 1'b0;
      btn_up = 1'b0;
      btn_down = 1'b0;
      lock_pin_n = 1'b1;
      dim_pin_n = 1'b1;
   end
   // b: 0 advance, 1 up, 2 down; hold sets a quick or slow press
   task press(input [1:0] b, input integer hold);
      begin
         @(posedge clock);
         btn_adv <= (b == 2'h0);
         btn_up <= (b == 2'h1);
         btn_down <= (b == 2'h2);
         repeat (hold) @(posedge clock);
         {btn_adv, btn_up, btn_down} <= 3'h0;
         repeat (6) @(posedge clock);
      end
   endtask
   // closing a contact ties the pin to common
   task contacts(input lock_c, input dim_c);
      begin
         @(posedge clock);
         lock_pin_n <= !lock_c;
         dim_pin_n <= !dim_c;
         repeat (5) @(posedge clock);
      end
   endtask
endmodule

//--- testbench/tb_top.sv
// Purpose: self-checking bench of the zone colour block
// Assumes: 20 MHz clock, register port answers one cycle later
// Notes:   expected values worked out here from the colour codes
`timescale 1ns/1ps
`include "bzc_consts.vh"

module tb_top;
   reg               clock = 1'b0;
   reg               rst_n = 1'b0;
   reg  [3:0]        addr = 4'h0;
   reg  [15:0]       wdata = 16'h0;
   reg               wr = 1'b0;
   reg               rd = 1'b0;
   reg               tri_s = 1'b0;
   reg               horiz = 1'b0;
   reg               rsd = 1'b0;
   reg  signed [13:0] reading = 14'h0;
   reg  [3:0]        sp = 4'h0;
   reg               nvr = 1'b0;
   reg  [9:0]        nv_d = 10'h0;
   wire [15:0]       rdata_q;
   wire              adv, up, down, lock_n, dim_n, nv_st, menu, bh;
   wire [9:0]        nv_wd;
   wire [2:0]        prompt;
   wire [1:0]        pcol, bar;
   wire [3:0]        relay;
   wire [7:0]        duty;
   integer           err_count = 0;
   integer           total_checks = 0;
   integer           k;
   reg  [15:0]       v;
   reg  [9:0]        old_c = 10'h290;
   reg  [9:0]        new_c = 10'h099;
   reg  [9:0]        act_c = 10'h1f9;

   always #25 clock = ~clock;

   bzc_top #(.DW(14)) i_bzc_top (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata_q(rdata_q), .btn_adv(adv), .btn_up(up), .btn_down(down), .lock_pin_n(lock_n), .dim_pin_n(dim_n),
      .tricolor_pin(tri_s), .horiz_pin(horiz), .relay_setup_done(rsd), .reading(reading), .sp_active(sp),
      .nv_restore(nvr), .nv_rdata(nv_d), .nv_store_q(nv_st), .nv_wdata_q(nv_wd), .menu_active_q(menu),
      .prompt_q(prompt), .prompt_color_q(pcol), .bar_color_q(bar), .bar_horiz_q(bh), .relay_q(relay),
      .duty_q(duty));
   bzc_operator i_bzc_operator (.clock(clock), .btn_adv(adv), .btn_up(up), .btn_down(down),
      .lock_pin_n(lock_n), .dim_pin_n(dim_n));

   ////////////////////////////////////////
   task chk(input [15:0] got, input [15:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wr_reg(input [3:0] a, input [15:0] d);
      begin
         @(posedge clock);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clock);
         wr <= 1'b0;
      end
   endtask
   // read data stand only in the cycle after the strobe
   task rd_reg(input [3:0] a, output [15:0] d);
      begin
         @(posedge clock);
         addr <= a;
         rd <= 1'b1;
         @(posedge clock);
         rd <= 1'b0;
         #1 d = rdata_q;
      end
   endtask
   task pulse_setup;
      begin
         @(posedge clock);
         rsd <= 1'b1;
         @(posedge clock);
         rsd <= 1'b0;
         repeat (2) @(posedge clock);
         #1;
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d errors %0d", total_checks, err_count);
         if (err_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask

   // watchdog: the sequence needs well under a millisecond
   initial begin
      #1000000;
      err_count = err_count + 1;
      complete_run;
   end

   initial begin
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      pulse_setup;
      chk(menu, 16'h0);
      rd_reg(`BZC_A_COLORS, v);
      chk(v, 16'h0290);
      // full colour walk, one slow advance among quick ones
      tri_s <= 1'b1;
      repeat (4) @(posedge clock);
      pulse_setup;
      for (k = 0; k < 5; k = k + 1) begin
         chk(prompt, `BZC_P_BELOW + k[2:0]);
         chk(pcol, old_c[2*k +: 2]);
         if (act_c[2*k +: 2] != 2'h3) begin
            i_bzc_operator.press(act_c[2*k +: 2], 4);
            chk(pcol, new_c[2*k +: 2]);
         end
         i_bzc_operator.press(2'h0, (k == 2) ? 20 : 3);
      end
      chk({menu, prompt}, 16'h0);
      chk(nv_wd, new_c);
      rd_reg(`BZC_A_COLORS, v);
      chk(v, {6'h0, new_c});
      // zones: first and second limits equal, second wins
      wr_reg(`BZC_A_LIM1, 16'h0064);
      wr_reg(`BZC_A_LIM2, 16'h0064);
      wr_reg(`BZC_A_LIM3, 16'h00c8);
      wr_reg(`BZC_A_LIM4, 16'h012c);
      for (k = 0; k < 4; k = k + 1) begin
         @(posedge clock);
         reading <= 14'h0032 + 14'h0064 * k[13:0];
         repeat (3) @(posedge clock);
         #1 chk(bar, 8'h25 >> (2 * k) & 8'h03);
      end
      for (k = 0; k < 16; k = k + 1) begin
         @(posedge clock);
         sp <= k[3:0];
         repeat (2) @(posedge clock);
         #1 chk(relay, {k[1], k[3], k[0], k[2]});
      end
      rd_reg(`BZC_A_RELAY, v);
      chk(v, 16'h000f);
      for (k = 0; k < 4; k = k + 1) begin
         wr_reg(`BZC_A_CTRL, k[15:0]);
         repeat (2) @(posedge clock);
         #1 chk(duty, 32'hffc08040 >> (8 * k) & 32'hff);
      end
      i_bzc_operator.contacts(1'b0, 1'b1);
      chk(duty, 16'h007f);
      wr_reg(`BZC_A_CTRL, 16'h0000);
      repeat (2) @(posedge clock);
      #1 chk(duty, 16'h0020);
      i_bzc_operator.contacts(1'b0, 1'b0);
      @(posedge clock);
      horiz <= 1'b1;
      repeat (4) @(posedge clock);
      #1 chk(bh, 16'h1);
      // locked: view yes, change no, menu still walks
      i_bzc_operator.contacts(1'b1, 1'b0);
      wr_reg(`BZC_A_COLORS, 16'h0155);
      rd_reg(`BZC_A_COLORS, v);
      chk(v, {6'h0, new_c});
      rd_reg(`BZC_A_STATUS, v);
      chk(v & 16'h0011, 16'h0011);
      wr_reg(`BZC_A_STATUS, 16'h0010);
      rd_reg(`BZC_A_STATUS, v);
      chk(v & 16'h0010, 16'h0000);
      pulse_setup;
      i_bzc_operator.press(2'h1, 4);
      chk(pcol, new_c[1:0]);
      rd_reg(`BZC_A_STATUS, v);
      chk(v & 16'h0018, 16'h0018);
      for (k = 0; k < 5; k = k + 1)
         i_bzc_operator.press(2'h0, 3);
      chk(menu, 16'h0);
      i_bzc_operator.contacts(1'b0, 1'b0);
      wr_reg(4'h8, 16'hffff);
      rd_reg(4'h8, v);
      chk(v, 16'h0000);
      @(posedge clock);
      nv_d <= 10'h155;
      nvr <= 1'b1;
      @(posedge clock);
      nvr <= 1'b0;
      rd_reg(`BZC_A_COLORS, v);
      chk(v, 16'h0155);
      // code 3 is kept as red, and the image goes out to the store
      wr_reg(`BZC_A_COLORS, 16'h02ff);
      #1 chk(nv_st, 16'h0001);
      chk(nv_wd, 16'h02aa);
      // second reset brings the default image back
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      rd_reg(`BZC_A_COLORS, v);
      chk(v, 16'h0290);
      complete_run;
   end
endmodule
